// ---- hdl/autoneg_defines.svh ----
`ifndef AUTONEG_DEFINES_SVH
`define AUTONEG_DEFINES_SVH

// register indices on the management port
`define REG_CTRL       5'h00
`define REG_BSTAT      5'h01
`define REG_DSTAT      5'h11
`define REG_OVERTIME   5'h12

// control register fields
`define CTRL_SOFT_RST  15
`define CTRL_AN_EN     12
`define CTRL_RESTART   9
`define CTRL_AN_EN_RST 1'b1

// basic status fields
`define BS_CMPL        5
`define BS_LINK        2

// detailed status fields
`define DS_RATE        15
`define DS_DUPLEX      14
`define DS_PROG_MSB    13
`define DS_PROG_LSB    11
`define DS_CMPL        4
`define DS_LINK        0

// progress codes
`define PROG_RST       4'h0
`define PROG_GOOD      4'h8
`define PROG_COMPLETE  4'hF

// state index to progress code, one nibble per state, idle in the low nibble
`define CODE_MAP_RST   40'h8F76543210

// typical negotiation time
`define AN_TYPICAL_MS  500
`define CLK_MHZ        200
`define AN_TYPICAL_CYC (`AN_TYPICAL_MS * 1000 * `CLK_MHZ)

`endif

// ---- hdl/autoneg_pkg.sv ----
package autoneg_pkg;

   typedef enum logic [3:0]
   {
      arb_idle,
      arb_tx_disable,
      arb_ability,
      arb_ack,
      arb_complete_ack,
      arb_idle_detect,
      arb_link_check,
      arb_parallel,
      arb_complete,
      arb_good
   } arb_state_t;

   typedef struct packed
   {
      logic ability_match;
      logic ack_match;
      logic ack_done;
      logic legacy_seen;
      logic link_ready;
      logic speed_100;
      logic full_duplex;
   } neg_evt_t;

   typedef struct packed
   {
      logic rx_signal_lost;
      logic pll_lock_err;
   } link_fault_t;

endpackage

// ---- hdl/restart_trigger.sv ----
`timescale 1ns/1ps
module restart_trigger
(
   input  wire logic clk_sys,
   input  wire logic arst_n,
   input  wire logic clk_en,
   input  wire logic restart_wr,
   input  wire logic enable,
   input  wire logic link_fail,
   output logic      restart_evt
);
`include "autoneg_defines.svh"

   logic en_prev_r;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         en_prev_r <= `CTRL_AN_EN_RST;
      else if (clk_en)
         en_prev_r <= enable;
   end

   // enable coming back high after a low spell restarts, as do the restart bit and a lost link
   assign restart_evt = restart_wr
                      | (enable & ~en_prev_r)
                      | link_fail;

endmodule

// ---- hdl/progress_latch.sv ----
`timescale 1ns/1ps
module progress_latch
#(
   parameter int W = 4
)
(
   input  wire logic         clk_sys,
   input  wire logic         arst_n,
   input  wire logic         clk_en,
   input  wire logic         clr,
   input  wire logic         rd_evt,
   input  wire logic [W-1:0] present,
   output logic      [W-1:0] held_r
);

   logic [W-1:0] held_nxt;

   always_comb
   begin
      held_nxt = held_r;
      if (clr)
         held_nxt = '0;
      else if (rd_evt)
         held_nxt = present;
      else if (present > held_r)
         held_nxt = present;
   end

   // restart is not an input here: the held code survives it
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         held_r <= '0;
      else if (clk_en)
         held_r <= held_nxt;
   end

endmodule

// ---- hdl/autoneg_progress_monitor.sv ----
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "autoneg_defines.svh"
module autoneg_progress_monitor
   import autoneg_pkg::*;
#(
   parameter logic [39:0] CODE_MAP    = `CODE_MAP_RST,
   parameter int unsigned TIMEOUT_CYC = `AN_TYPICAL_CYC
)
(
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic        clk_en,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire neg_evt_t    neg_in,
   input  wire link_fault_t fault_in,
   output logic             an_restart,
   output logic      [3:0]  present_code,
   output logic             link_up,
   output logic             an_complete
);

   arb_state_t  arb_r;
   arb_state_t  arb_nxt;
   logic        ctrl_en_r;
   logic        cmpl_r;
   logic        link_r;
   logic        speed_r;
   logic        duplex_r;
   logic        ovt_r;
   logic [31:0] cnt_r;
   logic [15:0] rdata_r;
   logic [3:0]  held;
   logic        ctrl_wr;
   logic        soft_rst;
   logic        restart_wr;
   logic        dstat_rd;
   logic        link_fault;
   logic        link_fail;
   logic        restart_evt;
   logic        cnt_hit;

   assign ctrl_wr    = reg_wr && (reg_addr == `REG_CTRL);
   assign soft_rst   = ctrl_wr && reg_wdata[`CTRL_SOFT_RST];
   // the restart bit is never stored, so it always reads back as zero
   assign restart_wr = ctrl_wr && reg_wdata[`CTRL_RESTART];
   assign dstat_rd   = reg_rd && (reg_addr == `REG_DSTAT);
   assign link_fault = fault_in.rx_signal_lost | fault_in.pll_lock_err;
   assign link_fail  = (arb_r == arb_good) && link_fault;

   restart_trigger u_restart
   (
      .clk_sys     (clk_sys),
      .arst_n      (arst_n),
      .clk_en      (clk_en),
      .restart_wr  (restart_wr),
      .enable      (ctrl_en_r),
      .link_fail   (link_fail),
      .restart_evt (restart_evt)
   );

   // control: enable bit, soft reset restores defaults
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_en_r <= `CTRL_AN_EN_RST;
      else if (clk_en)
      begin
         if (soft_rst)
            ctrl_en_r <= `CTRL_AN_EN_RST;
         else if (ctrl_wr)
            ctrl_en_r <= reg_wdata[`CTRL_AN_EN];
      end
   end

   // arbitration sequencer; the pulse exchange itself lives outside
   always_comb
   begin
      arb_nxt = arb_r;
      case (arb_r)
         arb_idle:
            if (ctrl_en_r)
               arb_nxt = arb_tx_disable;
         arb_tx_disable:
            arb_nxt = arb_ability;
         arb_ability:
            if (neg_in.legacy_seen)
               arb_nxt = arb_parallel;
            else if (neg_in.ability_match)
               arb_nxt = arb_ack;
         arb_ack:
            if (neg_in.ack_match)
               arb_nxt = arb_complete_ack;
         arb_complete_ack:
            if (neg_in.ack_done)
               arb_nxt = arb_idle_detect;
         arb_idle_detect:
            arb_nxt = arb_link_check;
         arb_link_check:
            if (neg_in.link_ready)
               arb_nxt = arb_complete;
         arb_parallel:
            if (neg_in.link_ready)
               arb_nxt = arb_complete;
         arb_complete:
            arb_nxt = arb_good;
         arb_good:
            arb_nxt = arb_good;
         default:
            arb_nxt = arb_idle;
      endcase
      if (!ctrl_en_r)
         arb_nxt = arb_idle;
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         arb_r <= arb_idle;
      else if (clk_en)
      begin
         if (soft_rst)
            arb_r <= arb_idle;
         else if (restart_evt)
            arb_r <= arb_idle;
         else
            arb_r <= arb_nxt;
      end
   end

   // complete pulses Fh for one cycle, then good settles on 8h
   assign present_code = CODE_MAP[{arb_r, 2'b00} +: 4];

   progress_latch #(.W(4)) u_progress
   (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .clr     (soft_rst),
      .rd_evt  (dstat_rd),
      .present (present_code),
      .held_r  (held)
   );

   // live completion and link indications
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cmpl_r   <= 1'b0;
         link_r   <= 1'b0;
         speed_r  <= 1'b0;
         duplex_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (soft_rst || restart_evt)
            cmpl_r <= 1'b0;
         else if (arb_r == arb_complete)
            cmpl_r <= 1'b1;
         if (soft_rst || restart_evt || link_fault)
            link_r <= 1'b0;
         else if (arb_r == arb_complete)
            link_r <= 1'b1;
         if (arb_r == arb_complete)
         begin
            speed_r  <= neg_in.speed_100;
            duplex_r <= neg_in.full_duplex;
         end
      end
   end

   // overrun of the typical negotiation time; sticky until restart or soft reset, set wins
   assign cnt_hit = (cnt_r == TIMEOUT_CYC - 32'd1);

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_r <= 32'h0000_0000;
         ovt_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (soft_rst || restart_evt || arb_r == arb_idle || cmpl_r)
            cnt_r <= 32'h0000_0000;
         else if (!cnt_hit)
            cnt_r <= cnt_r + 32'd1;
         if (cnt_hit && !cmpl_r)
            ovt_r <= 1'b1;
         else if (soft_rst || restart_evt)
            ovt_r <= 1'b0;
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         rdata_r <= 16'h0000;
      else if (clk_en)
      begin
         rdata_r <= 16'h0000;
         if (reg_rd)
         begin
            case (reg_addr)
               `REG_CTRL:
                  rdata_r[`CTRL_AN_EN] <= ctrl_en_r;
               `REG_BSTAT:
               begin
                  rdata_r[`BS_CMPL] <= cmpl_r;
                  rdata_r[`BS_LINK] <= link_r;
               end
               `REG_DSTAT:
               begin
                  rdata_r[`DS_RATE]   <= speed_r;
                  rdata_r[`DS_DUPLEX] <= duplex_r;
                  rdata_r[`DS_PROG_MSB:`DS_PROG_LSB] <= held[2:0];
                  rdata_r[`DS_CMPL]   <= held[3];
                  rdata_r[`DS_LINK]   <= link_r;
               end
               `REG_OVERTIME:
                  rdata_r[0] <= ovt_r;
               default:
                  rdata_r <= 16'h0000;
            endcase
         end
      end
   end

   assign reg_rdata   = rdata_r;
   assign an_restart  = restart_evt && clk_en;
   assign link_up     = link_r;
   assign an_complete = cmpl_r;

   default clocking cb @(posedge clk_sys);
   endclocking

   default disable iff (!arst_n);

   soft_reset_clears_a: assert property (clk_en && soft_rst |=> held == 4'h0 && arb_r == arb_idle)
      else $error("soft reset left progress or arbiter non-idle");

   restart_keeps_a: assert property (
      clk_en && restart_evt && !soft_rst && !dstat_rd && present_code <= held
      |=> $stable(held) && arb_r == arb_idle)
      else $error("restart disturbed held progress or arbiter");

   no_stray_change_a: assert property (
      clk_en && !soft_rst && !dstat_rd && present_code <= held |=> $stable(held))
      else $error("progress changed without cause");

   complete_hold_a: assert property (
      held == `PROG_COMPLETE && !soft_rst && !dstat_rd ##1 held != `PROG_COMPLETE |-> !$past(clk_en))
      else $error("completed progress altered without read or reset");

   link_fail_restart_a: assert property (
      arb_r == arb_good && link_fault && clk_en && !soft_rst |-> an_restart ##1 arb_r == arb_idle)
      else $error("link failure did not restart");

   restart_bit_a: assert property (
      clk_en && restart_wr && !soft_rst && !reg_wdata[`CTRL_SOFT_RST] |-> an_restart)
      else $error("restart bit write did not restart");

   enable_toggle_a: assert property ($rose(ctrl_en_r) && clk_en |-> an_restart)
      else $error("enable toggle did not restart");

   rate_duplex_a: assert property (
      clk_en && dstat_rd |=> reg_rdata[`DS_RATE] == $past(speed_r) && reg_rdata[`DS_DUPLEX] == $past(duplex_r))
      else $error("rate or duplex misreported");

   read_order_a: assert property (
      clk_en && dstat_rd |=> {reg_rdata[`DS_CMPL], reg_rdata[`DS_PROG_MSB:`DS_PROG_LSB]} == $past(held))
      else $error("read did not return the previously held code");

   code_set_a: assert property (held <= 4'h8 || held == 4'hF)
      else $error("progress code outside the legal set");

   rise_load_a: assert property (
      clk_en && !soft_rst && !dstat_rd && present_code > held |=> held == $past(present_code))
      else $error("higher state not latched");

   read_reload_a: assert property (clk_en && dstat_rd |=> held == $past(present_code))
      else $error("read did not reload the present state");

   good_after_read_a: assert property (
      clk_en && dstat_rd && arb_r == arb_good && !link_fault
      |=> held == `PROG_GOOD)
      else $error("established link did not reload 8h");

   complete_flag_a: assert property (clk_en && arb_r == arb_complete && !restart_evt && !soft_rst |=> cmpl_r)
      else $error("completion not flagged");

   fault_clears_link_a: assert property (clk_en && link_fault |=> !link_up)
      else $error("link fault left link up");

   first_read_full_a: assert property (
      clk_en && dstat_rd && held == `PROG_COMPLETE |=> reg_rdata[`DS_CMPL] && reg_rdata[`DS_PROG_MSB:`DS_PROG_LSB] == 3'h7)
      else $error("first read after completion not all ones");

   link_copy_a: assert property (clk_en && dstat_rd |=> reg_rdata[`DS_LINK] == $past(link_r))
      else $error("detailed status link copy wrong");

   restart_bit_clear_a: assert property (
      clk_en && reg_rd && reg_addr == `REG_CTRL |=> !reg_rdata[`CTRL_RESTART] && !reg_rdata[`CTRL_SOFT_RST])
      else $error("self-clearing control bit read back as one");

   basic_cmpl_a: assert property (
      clk_en && reg_rd && reg_addr == `REG_BSTAT |=> reg_rdata[`BS_CMPL] == $past(cmpl_r))
      else $error("basic status complete bit wrong");

   overrun_flag_a: assert property (clk_en && cnt_hit && !cmpl_r |=> ovt_r)
      else $error("overrun not flagged");

   complete_path_c: cover property (arb_r == arb_complete ##1 held == `PROG_COMPLETE);
   two_reads_c: cover property (dstat_rd && held == `PROG_COMPLETE ##[1:20] dstat_rd && held == `PROG_GOOD);
   fail_restart_c: cover property (link_fail && clk_en ##1 arb_r == arb_idle);
   parallel_path_c: cover property (arb_r == arb_parallel ##[1:20] arb_r == arb_good);

endmodule

// ---- verification/sta_model.sv ----
`timescale 1ns/1ps
`include "autoneg_defines.svh"
module station_manager
(
   input  wire logic   clk_sys,
   output logic [4:0]  reg_addr,
   output logic [15:0] reg_wdata,
   output logic        reg_wr,
   output logic        reg_rd
);
   initial
   begin
      reg_addr  = 5'h00;
      reg_wdata = 16'h0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // released lines show the inverse, so a stale value never passes for a live one
   task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr    <= wr;
      reg_rd    <= !wr;
      reg_addr  <= a;
      reg_wdata <= wr ? d : ~reg_wdata;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~reg_wdata;
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [4:0] a);
      xfer(1'b0, a, 16'h0000);
   endtask

   // first read gives the highest state reached, the second the present one
   task automatic rd_twice(input logic [4:0] a);
      rd(a);
      rd(a);
   endtask

   // link check: basic status first, then the partner ability index
   task automatic poll_link;
      rd(`REG_BSTAT);
      rd(5'h05);
   endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`include "autoneg_defines.svh"
module tb_top
   import autoneg_pkg::*;
;
   typedef struct packed {logic [15:0] val; logic [15:0] mask;} exp_t;
   logic        clk_sys, arst_n, clk_en, reg_wr, reg_rd;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   neg_evt_t    neg_in;
   link_fault_t fault_in;
   logic        an_restart, link_up, an_complete, rd_q, en_sh, rise_q, spd, dup, tk, wr9;
   logic [3:0]  present_code;
   exp_t        q[$];
   exp_t        e;
   int          error_cnt, n_compared, seed, rnd;

   autoneg_progress_monitor #(.TIMEOUT_CYC(50)) i_dut
   (
      .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .neg_in(neg_in), .fault_in(fault_in), .an_restart(an_restart),
      .present_code(present_code), .link_up(link_up), .an_complete(an_complete)
   );
   station_manager i_mgr
   (
      .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic fail(input string m);
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
   endtask

   task automatic report_and_stop;
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic rdx(input logic [4:0] a, input logic [15:0] v, input logic [15:0] m);
      q.push_back(exp_t'{v, m});
      i_mgr.rd(a);
   endtask

   function automatic logic [15:0] ds(input logic [3:0] c, input logic lk);
      return {spd, dup, c[2:0], 6'h00, c[3], 3'h0, lk};
   endfunction

   task automatic wait_cmpl;
      int n;
      for (n = 0; n < 100 && an_complete !== 1'b1; n++)
         @(posedge clk_sys);
      if (n == 100)
      begin
         fail("negotiation never completed");
         report_and_stop;
      end
   endtask

   // shadow of the enable bit, to know when a write turns it back on
   assign tk  = reg_wr && clk_en && reg_addr == `REG_CTRL;
   assign wr9 = tk && reg_wdata[`CTRL_RESTART];
   always @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         rd_q   <= 1'b0;
         en_sh  <= `CTRL_AN_EN_RST;
         rise_q <= 1'b0;
      end
      else
      begin
         rd_q   <= reg_rd && clk_en;
         rise_q <= tk && (reg_wdata[`CTRL_AN_EN] || reg_wdata[`CTRL_SOFT_RST]) && !en_sh;
         if (tk)
            en_sh <= reg_wdata[`CTRL_AN_EN] | reg_wdata[`CTRL_SOFT_RST];
      end

   always @(negedge clk_sys)
   begin
      n_compared++;
      if (!rd_q && reg_rdata !== 16'h0000) fail("read data outside its answer cycle");
      if (rd_q && q.size() == 0) fail("answer with nothing expected");
      if (rd_q && q.size() != 0)
      begin
         e = q.pop_front();
         if ((reg_rdata & e.mask) !== (e.val & e.mask)) fail("read data wrong");
      end
      if (!arst_n && {present_code, link_up, an_complete} !== 6'h00) fail("outputs in reset");
      if ((wr9 || rise_q) && an_restart !== 1'b1) fail("restart missing");
      // soft reset and fault cycles are left out of the no-restart check
      if (!wr9 && !rise_q && fault_in == 2'b00 && !(tk && reg_wdata[`CTRL_SOFT_RST]) && an_restart !== 1'b0)
         fail("restart without cause");
   end

   initial
   begin
      seed = 49;
      error_cnt = 0;
      n_compared = 0;
      arst_n = 1'b0;
      clk_en = 1'b1;
      neg_in = '0;
      fault_in = '0;
      {spd, dup} = 2'b00;
      repeat (16) @(posedge clk_sys);
      for (int it = 0; it < 2; it++)
      begin
         arst_n <= 1'b0;
         @(posedge clk_sys);
         arst_n <= 1'b1;
         rdx(`REG_DSTAT, 16'h0000, 16'h3811);
         rnd = $random(seed);
         spd = rnd[0];
         dup = rnd[1];
         // first pass exchanges abilities, second goes the legacy way
         neg_in <= {it == 0, 2'b11, it == 1, 1'b1, spd, dup};
         wait_cmpl;
         q.push_back(exp_t'{ds(4'hF, 1'b1), 16'hF811});
         q.push_back(exp_t'{ds(4'h8, 1'b1), 16'hF811});
         i_mgr.rd_twice(`REG_DSTAT);
         rdx(`REG_DSTAT, ds(4'h8, 1'b1), 16'hF811);
         q.push_back(exp_t'{16'h0024, 16'h0024});
         q.push_back(exp_t'{16'h0000, 16'hFFFF});
         i_mgr.poll_link;
         @(posedge clk_sys);
         fault_in <= 2'(it + 1);
         neg_in <= {5'h00, spd, dup};
         @(negedge clk_sys);
         n_compared++;
         if (an_restart !== 1'b1) fail("no restart on link fault");
         if (link_up !== 1'b1 || present_code !== `PROG_GOOD) fail("link not up before the fault");
         @(posedge clk_sys);
         fault_in <= 2'b00;
         rdx(`REG_BSTAT, 16'h0000, 16'h0004);
         q.push_back(exp_t'{ds(4'h8, 1'b0), 16'h3811});
         q.push_back(exp_t'{ds(4'h2, 1'b0), 16'h3811});
         i_mgr.rd_twice(`REG_DSTAT);
         // the last answer must be checked before reset drops again, or its note stays queued
         @(posedge clk_sys);
      end
      neg_in <= 7'h40;
      repeat (4) @(posedge clk_sys);
      neg_in <= 7'h00;
      i_mgr.wr(`REG_CTRL, 16'h1200);
      rdx(`REG_CTRL, 16'h1000, 16'h9200);
      rdx(`REG_DSTAT, ds(4'h3, 1'b0), 16'h3811);
      repeat (60) @(posedge clk_sys);
      rdx(`REG_OVERTIME, 16'h0001, 16'h0001);
      i_mgr.wr(`REG_CTRL, 16'h0000);
      i_mgr.wr(`REG_CTRL, 16'h1000);
      rdx(`REG_OVERTIME, 16'h0000, 16'h0001);
      i_mgr.wr(5'h05, 16'(rnd));
      rdx(5'h05, 16'h0000, 16'hFFFF);
      // strobes while the clock enable is low must be dropped
      @(posedge clk_sys);
      clk_en <= 1'b0;
      i_mgr.rd(`REG_DSTAT);
      // a taken write here would clear the enable bit, which the readback below would show
      i_mgr.wr(`REG_CTRL, 16'h0200);
      clk_en <= 1'b1;
      rdx(`REG_CTRL, 16'h1000, 16'h9200);
      i_mgr.wr(`REG_CTRL, 16'h9000);
      rdx(`REG_DSTAT, 16'h0000, 16'h3811);
      rdx(`REG_CTRL, 16'h1000, 16'h9200);
      repeat (2) @(posedge clk_sys);
      report_and_stop;
   end
endmodule
